// ==== gpb_consts.svh ====
`ifndef GPB_CONSTS_SVH
`define GPB_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define GPB_OFF_PORT 8'h00
`define GPB_OFF_LATCH 8'h01
`define GPB_OFF_DIR 8'h02
`define GPB_OFF_ICTL_MAIN 8'h03
`define GPB_OFF_ICTL_EDGE 8'h04
`define GPB_OFF_ICTL_EXT 8'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define GPB_BIT_CHANGE_FLAG 0
`define GPB_BIT_CHANGE_IRQ_EN 3
`define GPB_BIT_PULLUP_DIS_N 7
`define GPB_BIT_CHANGE_IRQ_PRI 0
`define GPB_PIN_CH2 3
`define GPB_PIN_PROG_CLK 6
`define GPB_PIN_PROG_DATA 7
`define GPB_CHG_LSB 4
`define GPB_CHG_MSB 7
`define GPB_EXT_IRQ_MSB 3

// ****************************************************************
// Reset values
// ****************************************************************
`define GPB_RST_LATCH 8'h00
`define GPB_RST_DIR 8'hFF
`define GPB_RST_ICTL_MAIN 8'h00
`define GPB_RST_ICTL_EDGE 8'hFF
`define GPB_RST_ICTL_EXT 8'h00
`define GPB_RST_RDATA 8'h00
`define GPB_RST_SNAP 4'h0

`endif

// ==== gpb_pkg.sv ====
// ****************************************************************
// Types shared by the port logic
// ****************************************************************
package gpb_pkg;

   // Source that drives one pad
   typedef enum logic [1:0] {
      GPB_DRV_HIZ = 2'b00,
      GPB_DRV_LATCH = 2'b01,
      GPB_DRV_CH2 = 2'b10,
      GPB_DRV_PROG = 2'b11
   } gpb_drv_t;

   typedef logic [7:0] gpb_byte_t;

   typedef logic [3:0] gpb_nib_t;

endpackage

// ==== gpb_chg_if.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Port logic to change detector
// ****************************************************************
interface gpb_chg_if;

   gpb_pkg::gpb_nib_t pins;
   gpb_pkg::gpb_nib_t cmp_mask;
   logic refresh;
   logic mismatch;

   modport port (
      output pins,
      output cmp_mask,
      output refresh,
      input mismatch
   );

   modport det (
      input pins,
      input cmp_mask,
      input refresh,
      output mismatch
   );

endinterface

// ==== gpb_chg_det.sv ====
`timescale 1ns/1ps
`include "gpb_consts.svh"

module gpb_chg_det (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Port side
   gpb_chg_if.det chg
);

   gpb_pkg::gpb_nib_t snap_r;
   logic primed_r;
   wire logic take_snap;
   wire gpb_pkg::gpb_nib_t diff;

   // Snapshot loads the pins in the first enabled cycle after reset, then only on refresh
   assign take_snap = chg.refresh | ~primed_r;
   assign diff = (chg.pins ^ snap_r) & chg.cmp_mask;

   // A refresh ends the mismatch in its own cycle
   assign chg.mismatch = (|diff) & ~take_snap;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         snap_r <= `GPB_RST_SNAP;
         primed_r <= 1'b0;
      end else if (i_ce) begin
         primed_r <= 1'b1;
         if (take_snap) begin
            snap_r <= chg.pins;
         end
      end
   end

endmodule // gpb_chg_det

// ==== gpb_port.sv ====
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "gpb_consts.svh"


module gpb_port (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_wr_move_dst,
   output logic [7:0] o_rdata,
   // Port pins
   input wire logic [7:0] i_pin,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe,
   output logic [7:0] o_pullup_en,
   // Device configuration
   input wire logic i_pkg_80pin,
   input wire logic i_mcu_mode,
   input wire logic i_ch2_pin_select_cfg,
   input wire logic i_prog_en,
   // Capture/compare/PWM channel 2
   input wire logic i_ch2_out,
   input wire logic i_ch2_out_en,
   output logic o_ch2_capture_in,
   // Programming link
   input wire logic i_program_data_out,
   input wire logic i_program_data_oe,
   output logic o_program_clock_in,
   output logic o_program_data_in,
   // External interrupt feeds
   output logic [3:0] o_ext_irq_in,
   // Change interrupt
   output logic o_change_flag,
   output logic o_change_irq,
   output logic o_change_irq_hi_pri,
   output logic o_wake_req
);

   // ****************************************************************
   // Decode helper
   // ****************************************************************
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   gpb_pkg::gpb_byte_t pin_meta_r;
   gpb_pkg::gpb_byte_t pin_sync_r;
   gpb_pkg::gpb_byte_t latch_r;
   gpb_pkg::gpb_byte_t dir_r;
   gpb_pkg::gpb_byte_t ictl_main_r;
   gpb_pkg::gpb_byte_t ictl_edge_r;
   gpb_pkg::gpb_byte_t ictl_ext_r;
   gpb_pkg::gpb_byte_t rdata_r;
   gpb_pkg::gpb_byte_t pin_out_r;
   gpb_pkg::gpb_byte_t pin_oe_r;
   gpb_pkg::gpb_byte_t pullup_en_r;
   logic [3:0] ext_irq_r;
   logic ch2_cap_r;
   logic prog_clk_r;
   logic prog_data_r;
   logic change_irq_r;
   logic change_pri_r;
   logic wake_r;

   // ****************************************************************
   // Register decode
   // ****************************************************************
   wire logic wr_port = i_wr & reg_hit(i_addr, `GPB_OFF_PORT);
   wire logic wr_latch = i_wr & reg_hit(i_addr, `GPB_OFF_LATCH);
   wire logic wr_dir = i_wr & reg_hit(i_addr, `GPB_OFF_DIR);
   wire logic wr_main = i_wr & reg_hit(i_addr, `GPB_OFF_ICTL_MAIN);
   wire logic wr_edge = i_wr & reg_hit(i_addr, `GPB_OFF_ICTL_EDGE);
   wire logic wr_ext = i_wr & reg_hit(i_addr, `GPB_OFF_ICTL_EXT);
   wire logic rd_port = i_rd & reg_hit(i_addr, `GPB_OFF_PORT);

   // ****************************************************************
   // Configuration terms
   // ****************************************************************
   // Plain microcontroller mode keeps channel 2 on its other alternate pin
   wire logic ch2_routed = i_pkg_80pin & ~i_mcu_mode & ~i_ch2_pin_select_cfg;
   wire logic pullup_on = ~ictl_edge_r[`GPB_BIT_PULLUP_DIS_N];
   wire logic flag_now = ictl_main_r[`GPB_BIT_CHANGE_FLAG];
   wire logic irq_en = ictl_main_r[`GPB_BIT_CHANGE_IRQ_EN];

   // Pins owned by the programming link
   wire gpb_pkg::gpb_byte_t prog_mask = i_prog_en ?
      8'hC0 : 8'h00;

   // ****************************************************************
   // Pad drive selection
   // ****************************************************************
   gpb_pkg::gpb_byte_t pin_out_nxt;
   gpb_pkg::gpb_byte_t pin_oe_nxt;
   gpb_pkg::gpb_byte_t pullup_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pad
         gpb_pkg::gpb_drv_t sel;
         if (gi == `GPB_PIN_PROG_CLK || gi == `GPB_PIN_PROG_DATA) begin : g_prog
            assign sel = i_prog_en ? gpb_pkg::GPB_DRV_PROG :
               dir_r[gi] ? gpb_pkg::GPB_DRV_HIZ :
               gpb_pkg::GPB_DRV_LATCH;
         end else if (gi == `GPB_PIN_CH2) begin : g_ch2
            // Direction must be cleared by software for the override to show
            assign sel = dir_r[gi] ? gpb_pkg::GPB_DRV_HIZ :
               (ch2_routed & i_ch2_out_en) ? gpb_pkg::GPB_DRV_CH2 :
               gpb_pkg::GPB_DRV_LATCH;
         end else begin : g_plain
            assign sel = dir_r[gi] ? gpb_pkg::GPB_DRV_HIZ :
               gpb_pkg::GPB_DRV_LATCH;
         end

         always_comb begin
            unique case (sel)
               gpb_pkg::GPB_DRV_HIZ: begin
                  pin_out_nxt[gi] = 1'b0;
                  pin_oe_nxt[gi] = 1'b0;
               end
               gpb_pkg::GPB_DRV_LATCH: begin
                  pin_out_nxt[gi] = latch_r[gi];
                  pin_oe_nxt[gi] = 1'b1;
               end
               gpb_pkg::GPB_DRV_CH2: begin
                  pin_out_nxt[gi] = i_ch2_out;
                  pin_oe_nxt[gi] = 1'b1;
               end
               gpb_pkg::GPB_DRV_PROG: begin
                  // Clock pin is input only; data pin follows the link
                  pin_out_nxt[gi] = (gi == `GPB_PIN_PROG_DATA) & i_program_data_out;
                  pin_oe_nxt[gi] = (gi == `GPB_PIN_PROG_DATA) & i_program_data_oe;
               end
            endcase
         end

         // Weak pull-up only on undriven pins outside programming
         assign pullup_nxt[gi] = pullup_on & ~pin_oe_nxt[gi] & ~prog_mask[gi];
      end
   endgenerate

   // ****************************************************************
   // External interrupt feeds
   // ****************************************************************
   wire logic [3:0] ext_irq_nxt = pin_sync_r[`GPB_EXT_IRQ_MSB:0] &
      dir_r[`GPB_EXT_IRQ_MSB:0];

   // ****************************************************************
   // Change detection
   // ****************************************************************
   gpb_chg_if chg ();

   // Move-destination writes leave the snapshot alone
   wire logic port_access = rd_port | (wr_port & ~i_wr_move_dst);

   assign chg.pins = pin_sync_r[`GPB_CHG_MSB:`GPB_CHG_LSB];
   assign chg.cmp_mask = dir_r[`GPB_CHG_MSB:`GPB_CHG_LSB] &
      ~prog_mask[`GPB_CHG_MSB:`GPB_CHG_LSB];
   assign chg.refresh = port_access & i_ce;

   gpb_chg_det u_chg_det (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .chg(chg)
   );

   // Hardware set beats a same-cycle software clear
   wire logic flag_nxt = chg.mismatch |
      (wr_main ? i_wdata[`GPB_BIT_CHANGE_FLAG] : flag_now);

   wire gpb_pkg::gpb_byte_t main_nxt = wr_main ?
      {i_wdata[7:1], flag_nxt} : {ictl_main_r[7:1], flag_nxt};

   // ****************************************************************
   // Read data
   // ****************************************************************
   // Port reads show pin levels; programming pins read as zero
   wire gpb_pkg::gpb_byte_t port_view = pin_sync_r & ~prog_mask;

   wire gpb_pkg::gpb_byte_t rdata_nxt =
      ~i_rd ? `GPB_RST_RDATA :
      reg_hit(i_addr, `GPB_OFF_PORT) ? port_view :
      reg_hit(i_addr, `GPB_OFF_LATCH) ? latch_r :
      reg_hit(i_addr, `GPB_OFF_DIR) ? dir_r :
      reg_hit(i_addr, `GPB_OFF_ICTL_MAIN) ? ictl_main_r :
      reg_hit(i_addr, `GPB_OFF_ICTL_EDGE) ? ictl_edge_r :
      reg_hit(i_addr, `GPB_OFF_ICTL_EXT) ? ictl_ext_r :
      `GPB_RST_RDATA;

   // ****************************************************************
   // Pin synchroniser
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pin_meta_r <= 8'h00;
         pin_sync_r <= 8'h00;
      end else if (i_ce) begin
         pin_meta_r <= i_pin;
         pin_sync_r <= pin_meta_r;
      end
   end

   // ****************************************************************
   // Software registers
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         latch_r <= `GPB_RST_LATCH;
         dir_r <= `GPB_RST_DIR;
         ictl_main_r <= `GPB_RST_ICTL_MAIN;
         ictl_edge_r <= `GPB_RST_ICTL_EDGE;
         ictl_ext_r <= `GPB_RST_ICTL_EXT;
      end else if (i_ce) begin
         // Either address loads the same latch
         if (wr_port | wr_latch) begin
            latch_r <= i_wdata;
         end
         if (wr_dir) begin
            dir_r <= i_wdata;
         end
         ictl_main_r <= main_nxt;
         if (wr_edge) begin
            ictl_edge_r <= i_wdata;
         end
         if (wr_ext) begin
            ictl_ext_r <= i_wdata;
         end
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   // Pads lag their controls by one cycle so every output is a flop
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdata_r <= `GPB_RST_RDATA;
         pin_out_r <= 8'h00;
         pin_oe_r <= 8'h00;
         pullup_en_r <= 8'h00;
         ext_irq_r <= 4'h0;
      end else if (i_ce) begin
         rdata_r <= rdata_nxt;
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
         pullup_en_r <= pullup_nxt;
         ext_irq_r <= ext_irq_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ch2_cap_r <= 1'b0;
         prog_clk_r <= 1'b0;
         prog_data_r <= 1'b0;
         change_irq_r <= 1'b0;
         change_pri_r <= 1'b0;
         wake_r <= 1'b0;
      end else if (i_ce) begin
         ch2_cap_r <= ch2_routed & dir_r[`GPB_PIN_CH2] & pin_sync_r[`GPB_PIN_CH2];
         prog_clk_r <= i_prog_en & pin_sync_r[`GPB_PIN_PROG_CLK];
         prog_data_r <= i_prog_en & pin_sync_r[`GPB_PIN_PROG_DATA];
         change_irq_r <= flag_nxt & irq_en;
         change_pri_r <= ictl_edge_r[`GPB_BIT_CHANGE_IRQ_PRI];
         // Wake needs no global enable, only the change enable
         wake_r <= flag_nxt & irq_en;
      end
   end

   assign o_rdata = rdata_r;
   assign o_pin_out = pin_out_r;
   assign o_pin_oe = pin_oe_r;
   assign o_pullup_en = pullup_en_r;
   assign o_ch2_capture_in = ch2_cap_r;
   assign o_program_clock_in = prog_clk_r;
   assign o_program_data_in = prog_data_r;
   assign o_ext_irq_in = ext_irq_r;
   assign o_change_flag = flag_now;
   assign o_change_irq = change_irq_r;
   assign o_change_irq_hi_pri = change_pri_r;
   assign o_wake_req = wake_r;

endmodule // gpb_port

// ==== gpb_port_props.sv ====
`timescale 1ns/1ps
`include "gpb_consts.svh"

module gpb_port_props (
   // Clock, reset and enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Pins and configuration
   input wire logic [7:0] o_pin_out,
   input wire logic [7:0] o_pin_oe,
   input wire logic [7:0] o_pullup_en,
   input wire logic i_pkg_80pin,
   input wire logic i_mcu_mode,
   input wire logic i_ch2_pin_select_cfg,
   input wire logic i_prog_en,
   input wire logic i_ch2_out,
   input wire logic i_ch2_out_en,
   // Interrupt side
   input wire logic [3:0] o_ext_irq_in,
   input wire logic o_change_flag,
   input wire logic o_change_irq,
   input wire logic o_wake_req
);
   wire dir_wr;
   wire lat_wr;
   wire ch2_routed;
   assign dir_wr = i_ce && i_wr && (i_addr == `GPB_OFF_DIR);
   assign lat_wr = i_ce && i_wr && (i_addr == `GPB_OFF_LATCH || i_addr == `GPB_OFF_PORT);
   assign ch2_routed = i_pkg_80pin && !i_mcu_mode && !i_ch2_pin_select_cfg;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   AST_RST_QUIET: assert property ($past(i_sys_rst) |-> o_pin_oe == 8'h00 && o_pullup_en == 8'h00)
      else $error("pins not quiet after reset");
   AST_RDATA_IDLE: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
   AST_DIR_TO_OE: assert property (dir_wr ##1 i_ce |=> o_pin_oe[5:0] == ~$past(i_wdata[5:0], 2))
      else $error("output enable does not follow direction");
   AST_LATCH_DRIVE: assert property (lat_wr ##1 i_ce |=>
      ((o_pin_out ^ $past(i_wdata, 2)) & o_pin_oe & 8'h37) == 8'h00)
      else $error("driven pin differs from latch");
   AST_PULLUP_OUT: assert property ((o_pullup_en & o_pin_oe) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_WAKE: assert property (o_wake_req == o_change_irq)
      else $error("wake request differs from change irq");
   AST_IRQ_CAUSE: assert property ($rose(o_change_irq) |-> o_change_flag)
      else $error("change irq without flag");
   AST_EXT_INPUT: assert property ((o_ext_irq_in & o_pin_oe[3:0]) == 4'h0)
      else $error("external irq fed from output pin");
   AST_CH2_WINS: assert property ($past(ch2_routed && i_ch2_out_en && i_ce) && o_pin_oe[3]
      |-> o_pin_out[3] == $past(i_ch2_out))
      else $error("channel 2 does not own pin 3");
   AST_PROG_PINS: assert property (i_prog_en && $past(i_prog_en)
      |-> !o_pin_oe[6] && o_pullup_en[7:6] == 2'b00)
      else $error("programming pins not released");

   cover property ($rose(o_change_flag));
   cover property (o_rdata != 8'h00);
   cover property (o_pin_oe[3] && ch2_routed && i_ch2_out_en);
endmodule // gpb_port_props

bind gpb_port gpb_port_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en),
   .i_pkg_80pin(i_pkg_80pin), .i_mcu_mode(i_mcu_mode),
   .i_ch2_pin_select_cfg(i_ch2_pin_select_cfg), .i_prog_en(i_prog_en),
   .i_ch2_out(i_ch2_out), .i_ch2_out_en(i_ch2_out_en), .o_ext_irq_in(o_ext_irq_in),
   .o_change_flag(o_change_flag), .o_change_irq(o_change_irq), .o_wake_req(o_wake_req));

// ==== gpb_pad_model.sv ====
`timescale 1ns/1ps

module gpb_pad_model (
   // Clock
   input wire logic i_clk,
   // Device side
   input wire logic [7:0] i_drv_val,
   input wire logic [7:0] i_drv_oe,
   input wire logic [7:0] i_pull_en,
   // Board side
   input wire logic [7:0] i_ext_val,
   input wire logic [7:0] i_ext_en,
   output logic [7:0] o_level
);
   logic [7:0] float_r = 8'h00;

   // Undriven pads wander, so a missing pull-up never reads as a clean level
   always @(posedge i_clk) begin
      float_r <= ~o_level;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (i_drv_oe[i]) o_level[i] = i_drv_val[i];
         else if (i_ext_en[i]) o_level[i] = i_ext_val[i];
         else if (i_pull_en[i]) o_level[i] = 1'b1;
         else o_level[i] = float_r[i];
      end
   end
endmodule // gpb_pad_model

// ==== gpio_port_b_change_irq_tb.sv ====
`timescale 1ns/1ps
`include "gpb_consts.svh"

module gpio_port_b_change_irq_tb;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_wr = 1'b0, i_rd = 1'b0, i_wr_move_dst = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, ext_val = 8'h00, ext_en = 8'hFF;
   logic pkg = 1'b1, mcu = 1'b0, sel = 1'b0, prog = 1'b0;
   logic ce = 1'b1;
   logic ch2_out = 1'b0, ch2_en = 1'b0, pdo = 1'b0, pdoe = 1'b0;
   logic [7:0] o_rdata, o_pin_out, o_pin_oe, o_pullup_en, pin;
   logic [3:0] o_ext_irq_in;
   logic cap, pclk, pdin, flag, irq, hipri, wake;
   logic [7:0] d;
   int n_fail = 0, total_checks = 0, cyc = 0;

   gpb_port uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_wr_move_dst(i_wr_move_dst),
      .o_rdata(o_rdata), .i_pin(pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
      .o_pullup_en(o_pullup_en), .i_pkg_80pin(pkg), .i_mcu_mode(mcu),
      .i_ch2_pin_select_cfg(sel), .i_prog_en(prog), .i_ch2_out(ch2_out),
      .i_ch2_out_en(ch2_en), .o_ch2_capture_in(cap), .i_program_data_out(pdo),
      .i_program_data_oe(pdoe), .o_program_clock_in(pclk), .o_program_data_in(pdin),
      .o_ext_irq_in(o_ext_irq_in), .o_change_flag(flag), .o_change_irq(irq),
      .o_change_irq_hi_pri(hipri), .o_wake_req(wake));

   gpb_pad_model pads (.i_clk(i_clk), .i_drv_val(o_pin_out), .i_drv_oe(o_pin_oe),
      .i_pull_en(o_pullup_en), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pin));

   always #4 i_clk = ~i_clk;

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task conclude();
      if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Move into the port register: latch loads, snapshot kept
   task wr_move(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      i_wr_move_dst <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_wr_move_dst <= 1'b0;
   endtask

   task rd(input logic [7:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task chk_rd(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(d, exp);
   endtask

   task idle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // One port read, one spare cycle, then the flag clear
   task clear();
      rd(`GPB_OFF_PORT);
      idle(1);
      wr(`GPB_OFF_ICTL_MAIN, 8'h08);
      idle(2);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      idle(1);
      chk(o_pullup_en, 8'h00);
      chk(o_pin_oe, 8'h00);
      chk({7'h00, hipri}, 8'h01);
      chk_rd(`GPB_OFF_LATCH, 8'h00);
      chk_rd(`GPB_OFF_DIR, 8'hFF);
      chk_rd(`GPB_OFF_ICTL_MAIN, 8'h00);
      chk_rd(`GPB_OFF_ICTL_EDGE, 8'hFF);
      chk_rd(`GPB_OFF_ICTL_EXT, 8'h00);
      chk_rd(8'h06, 8'h00);
      ext_val <= 8'hA5;
      idle(4);
      chk_rd(`GPB_OFF_PORT, 8'hA5);
      wr(`GPB_OFF_LATCH, 8'h30);
      wr(`GPB_OFF_DIR, 8'hCF);
      idle(4);
      chk(o_pin_oe, 8'h30);
      chk(o_pin_out & 8'h30, 8'h30);
      chk_rd(`GPB_OFF_PORT, 8'hB5);
      chk_rd(`GPB_OFF_LATCH, 8'h30);
      wr(`GPB_OFF_PORT, 8'h10);
      chk_rd(`GPB_OFF_LATCH, 8'h10);
      // Enable low: a write must not land
      @(posedge i_clk);
      ce <= 1'b0;
      wr(`GPB_OFF_LATCH, 8'h55);
      ce <= 1'b1;
      chk_rd(`GPB_OFF_LATCH, 8'h10);
      wr(`GPB_OFF_ICTL_EDGE, 8'h7F);
      idle(2);
      chk(o_pullup_en, 8'hCF);
      ext_en <= 8'h00;
      idle(4);
      chk_rd(`GPB_OFF_PORT, 8'hDF);
      ext_en <= 8'hFF;
      wr(`GPB_OFF_ICTL_EDGE, 8'hFF);
      idle(2);
      chk(o_pullup_en, 8'h00);
      ext_val <= 8'h00;
      wr(`GPB_OFF_DIR, 8'hFF);
      idle(4);
      clear();
      chk({7'h00, flag}, 8'h00);
      ext_val <= 8'h20;
      idle(5);
      chk({5'h00, flag, irq, wake}, 8'h07);
      wr(`GPB_OFF_ICTL_MAIN, 8'h08);
      idle(2);
      chk({7'h00, flag}, 8'h01);
      clear();
      chk({7'h00, flag}, 8'h00);
      ext_val <= 8'h21;
      wr(`GPB_OFF_DIR, 8'hEF);
      wr(`GPB_OFF_LATCH, 8'h00);
      idle(5);
      chk({7'h00, flag}, 8'h00);
      ext_val <= 8'h61;
      idle(5);
      wr_move(`GPB_OFF_PORT, 8'h00);
      idle(1);
      wr(`GPB_OFF_ICTL_MAIN, 8'h08);
      idle(2);
      chk({7'h00, flag}, 8'h01);
      wr(`GPB_OFF_PORT, 8'h00);
      idle(1);
      wr(`GPB_OFF_ICTL_MAIN, 8'h08);
      idle(2);
      chk({7'h00, flag}, 8'h00);
      ext_val <= 8'h0A;
      wr(`GPB_OFF_DIR, 8'hFF);
      idle(4);
      chk({4'h0, o_ext_irq_in}, 8'h0A);
      wr(`GPB_OFF_DIR, 8'hF0);
      idle(2);
      chk({4'h0, o_ext_irq_in}, 8'h00);
      wr(`GPB_OFF_DIR, 8'hF7);
      ch2_en <= 1'b1;
      ch2_out <= 1'b1;
      idle(3);
      chk({6'h00, o_pin_oe[3], o_pin_out[3]}, 8'h03);
      @(posedge i_clk);
      ch2_out <= 1'b0;
      idle(2);
      chk({6'h00, o_pin_oe[3], o_pin_out[3]}, 8'h02);
      ext_val <= 8'h08;
      wr(`GPB_OFF_DIR, 8'hFF);
      idle(4);
      chk({7'h00, cap}, 8'h01);
      @(posedge i_clk);
      mcu <= 1'b1;
      idle(3);
      chk({7'h00, cap}, 8'h00);
      @(posedge i_clk);
      prog <= 1'b1;
      pdoe <= 1'b1;
      pdo <= 1'b1;
      ext_val <= 8'h48;
      idle(4);
      chk({o_pin_oe[7:6], o_pin_out[7], pclk, 4'h0}, 8'hB0);
      chk({7'h00, pdin}, 8'h01);
      chk_rd(`GPB_OFF_PORT, 8'h08);
      conclude();
   end
endmodule // gpio_port_b_change_irq_tb
